/* File: interval_timer.sv */
// interval and time-base timer with axi4-lite registers and clock output
`timescale 1ns/100ps
module interval_timer (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [interval_timer_pkg::ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [interval_timer_pkg::ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic subclk_in,
  input wire logic [2:0] power_mode_in,
  input wire logic clkout_enable_in,
  output logic divided_clock_out,
  output logic irq_out
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0] mode_r;
  logic [7:0] count_r;
  logic [interval_timer_pkg::SYS_PRE_W-1:0] sys_pre_r;
  logic [interval_timer_pkg::SUB_PRE_W-1:0] sub_pre_r;
  logic sub_meta_r;
  logic sub_sync_r;
  logic sub_prev_r;
  logic sub_tick;
  logic overflow_request_flag_r;
  logic overflow_irq_enable_r;
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic aw_full_r;
  logic w_full_r;
  logic [15:0] aw_idx_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic arready_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  logic clkout_r;
  logic irq_r;
  logic do_write;
  logic lane0_write;
  logic [15:0] ar_idx;
  logic [3:0] count_src;
  logic base_mode_sel;
  logic hold_clear;
  logic run_interval;
  logic run_base;
  logic sys_hit;
  logic sub_hit;
  logic count_tick;
  logic overflow;
  logic out_wave;
  logic out_allowed;
  logic [2:0] clkout_sel;
  logic pm_active;
  logic pm_sleep;
  logic pm_subactive;
  logic pm_standby;

  assign s_axi_awready_out = awready_r;
  assign s_axi_wready_out = wready_r;
  assign s_axi_bvalid_out = bvalid_r;
  assign s_axi_bresp_out = bresp_r;
  assign s_axi_arready_out = arready_r;
  assign s_axi_rvalid_out = rvalid_r;
  assign s_axi_rresp_out = rresp_r;
  assign s_axi_rdata_out = rdata_r;
  assign divided_clock_out = clkout_r;
  assign irq_out = irq_r;

  assign pm_active = power_mode_in == interval_timer_pkg::PM_ACTIVE;
  assign pm_sleep = power_mode_in == interval_timer_pkg::PM_SLEEP;
  assign pm_subactive = power_mode_in == interval_timer_pkg::PM_SUBACTIVE;
  assign pm_standby = power_mode_in == interval_timer_pkg::PM_STANDBY;

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  // address and data are parked independently; the response waits for both
  assign do_write = aw_full_r && w_full_r && !bvalid_r;
  assign lane0_write = do_write && w_strb_r[0];

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      aw_idx_r <= 16'h0000;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= interval_timer_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in && awready_r) begin
        aw_full_r <= 1'b1;
        awready_r <= 1'b0;
        aw_idx_r <= s_axi_awaddr_in[interval_timer_pkg::ADDR_W-1:2];
      end
      if (s_axi_wvalid_in && wready_r) begin
        w_full_r <= 1'b1;
        wready_r <= 1'b0;
        w_data_r <= s_axi_wdata_in;
        w_strb_r <= s_axi_wstrb_in;
      end
      if (do_write) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        bvalid_r <= 1'b1;
        case (aw_idx_r)
          interval_timer_pkg::MODE_IDX,
          interval_timer_pkg::COUNT_IDX,
          interval_timer_pkg::STAT_IDX,
          interval_timer_pkg::MASK_IDX: bresp_r <= interval_timer_pkg::RESP_OKAY;
          default: bresp_r <= interval_timer_pkg::RESP_SLVERR;
        endcase
      end
      if (bvalid_r && s_axi_bready_in) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  assign ar_idx = s_axi_araddr_in[interval_timer_pkg::ADDR_W-1:2];

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rresp_r <= interval_timer_pkg::RESP_OKAY;
      rdata_r <= 32'h00000000;
    end else if (s_axi_arvalid_in && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rresp_r <= interval_timer_pkg::RESP_OKAY;
      rdata_r <= 32'h00000000;
      case (ar_idx)
        interval_timer_pkg::MODE_IDX: rdata_r <= {24'h000000, mode_r | interval_timer_pkg::RSVD_MASK};
        // the cpu runs off the subclock in subactive, the count is not coherent then
        interval_timer_pkg::COUNT_IDX: rdata_r <= pm_subactive ? 32'h00000000 : {24'h000000, count_r};
        interval_timer_pkg::STAT_IDX: rdata_r <= {31'h0, overflow_request_flag_r};
        interval_timer_pkg::MASK_IDX: rdata_r <= {31'h0, overflow_irq_enable_r};
        default: rresp_r <= interval_timer_pkg::RESP_SLVERR;
      endcase
    end else if (rvalid_r && s_axi_rready_in) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // mode and mask registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      mode_r <= interval_timer_pkg::MODE_RST;
    end else if (lane0_write && aw_idx_r == interval_timer_pkg::MODE_IDX) begin
      mode_r <= w_data_r[7:0] | interval_timer_pkg::RSVD_MASK;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      overflow_irq_enable_r <= 1'b0;
    end else if (lane0_write && aw_idx_r == interval_timer_pkg::MASK_IDX) begin
      overflow_irq_enable_r <= w_data_r[interval_timer_pkg::OVF_BIT];
    end
  end

  // ----------------------------------------------------------------
  // subclock synchroniser and prescalers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      sub_meta_r <= 1'b0;
      sub_sync_r <= 1'b0;
      sub_prev_r <= 1'b0;
    end else begin
      sub_meta_r <= subclk_in;
      sub_sync_r <= sub_meta_r;
      sub_prev_r <= sub_sync_r;
    end
  end

  assign sub_tick = sub_sync_r && !sub_prev_r;
  assign count_src = mode_r[3:0];
  assign base_mode_sel = count_src[interval_timer_pkg::BASE_BIT];
  assign hold_clear = base_mode_sel && count_src[interval_timer_pkg::CLR_BIT];

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      sys_pre_r <= '0;
    end else begin
      sys_pre_r <= sys_pre_r + 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      sub_pre_r <= '0;
    end else if (hold_clear) begin
      sub_pre_r <= '0;
    end else if (sub_tick) begin
      sub_pre_r <= sub_pre_r + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // count tick selection
  // ----------------------------------------------------------------
  // a tap fires in the one cycle where all prescaler bits below it are ones
  always_comb begin
    case (count_src[2:0])
      3'h0: sys_hit = &sys_pre_r[12:0];
      3'h1: sys_hit = &sys_pre_r[11:0];
      3'h2: sys_hit = &sys_pre_r[10:0];
      3'h3: sys_hit = &sys_pre_r[8:0];
      3'h4: sys_hit = &sys_pre_r[7:0];
      3'h5: sys_hit = &sys_pre_r[6:0];
      3'h6: sys_hit = &sys_pre_r[4:0];
      default: sys_hit = &sys_pre_r[2:0];
    endcase
  end

  // 256 ticks of subclock /128, /64, /32, /4 give 1, 0.5, 0.25, 0.03125 s
  always_comb begin
    case (count_src[1:0])
      2'h0: sub_hit = &sub_pre_r[6:0];
      2'h1: sub_hit = &sub_pre_r[5:0];
      2'h2: sub_hit = &sub_pre_r[4:0];
      default: sub_hit = &sub_pre_r[1:0];
    endcase
  end

  assign run_interval = pm_active || pm_sleep;
  assign run_base = !pm_standby;
  assign count_tick = base_mode_sel ?
    (!hold_clear && run_base && sub_tick && sub_hit) : (run_interval && sys_hit);
  assign overflow = count_tick && count_r == 8'hFF;

  // ----------------------------------------------------------------
  // counter, overflow flag and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      count_r <= interval_timer_pkg::COUNT_RST;
    end else if (hold_clear) begin
      count_r <= 8'h00;
    end else if (count_tick) begin
      count_r <= count_r + 8'h01;
    end
  end

  // a new overflow beats a same-cycle write-one-to-clear
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      overflow_request_flag_r <= 1'b0;
    end else if (overflow) begin
      overflow_request_flag_r <= 1'b1;
    end else if (lane0_write && aw_idx_r == interval_timer_pkg::STAT_IDX &&
                 w_data_r[interval_timer_pkg::OVF_BIT]) begin
      overflow_request_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= overflow_request_flag_r && overflow_irq_enable_r;
    end
  end

  // ----------------------------------------------------------------
  // clock output
  // ----------------------------------------------------------------
  assign clkout_sel = mode_r[7:interval_timer_pkg::CLKOUT_LSB];

  always_comb begin
    case (clkout_sel)
      3'h0: out_wave = sys_pre_r[4];
      3'h1: out_wave = sys_pre_r[3];
      3'h2: out_wave = sys_pre_r[2];
      3'h3: out_wave = sys_pre_r[1];
      3'h4: out_wave = sub_pre_r[4];
      3'h5: out_wave = sub_pre_r[3];
      3'h6: out_wave = sub_pre_r[2];
      default: out_wave = sub_pre_r[1];
    endcase
  end

  assign out_allowed = clkout_sel[2] ? (pm_active || pm_sleep || pm_subactive)
                                     : (pm_active || pm_sleep);

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      clkout_r <= 1'b0;
    end else begin
      clkout_r <= clkout_enable_in && out_allowed && out_wave;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  a_reserved_reads_one: assert property (mode_r[4] == 1'b1)
    else $error("reserved mode bit not one");
  a_clear_holds_zero: assert property (hold_clear |=> count_r == 8'h00 && sub_pre_r == '0)
    else $error("counter or subclock prescaler not held at zero");
  a_overflow_wraps: assert property (overflow && !hold_clear |=>
      count_r == 8'h00 && overflow_request_flag_r)
    else $error("overflow did not wrap and set flag");
  a_count_step: assert property (count_tick && !hold_clear && count_r != 8'hFF |=>
      count_r == $past(count_r) + 8'h01)
    else $error("counter did not step by one");
  a_count_stable: assert property (!count_tick && !hold_clear |=> $stable(count_r))
    else $error("counter moved without a tick");
  a_interval_halts: assert property (!base_mode_sel && !run_interval |-> !count_tick)
    else $error("interval counting outside active or sleep");
  a_standby_halts: assert property (base_mode_sel && pm_standby |=> $stable(count_r))
    else $error("time base counted in standby");
  a_slow_tap_spacing: assert property (!base_mode_sel && count_src[2:0] == 3'h7 && count_tick
      |=> !count_tick [*7])
    else $error("divide-by-8 tap fired too soon");
  a_pin_disabled: assert property (!clkout_enable_in |=> !divided_clock_out)
    else $error("clock output driven while disabled");
  a_sys_out_gated: assert property (!clkout_sel[2] && !(pm_active || pm_sleep)
      |=> !divided_clock_out)
    else $error("system clock output outside active or sleep");
  a_sub_out_gated: assert property (clkout_sel[2] && !(pm_active || pm_sleep || pm_subactive)
      |=> !divided_clock_out)
    else $error("subclock output in a stopped mode");
  a_irq_follows: assert property (overflow && overflow_irq_enable_r && !hold_clear
      |-> ##2 irq_out)
    else $error("enabled overflow gave no interrupt");
  a_sub_sync_path: assert property ($rose(subclk_in) ##1 subclk_in [*3] |-> ##0 sub_prev_r
      or ##1 sub_prev_r)
    else $error("subclock edge not seen within synchroniser delay");
  c_interval_overflow: cover property (overflow && !base_mode_sel);
  c_base_overflow: cover property (overflow && base_mode_sel);
  c_sub_clkout: cover property (clkout_sel[2] && clkout_enable_in ##1 divided_clock_out);
  c_flag_cleared: cover property (overflow_request_flag_r ##1 !overflow_request_flag_r);
endmodule

/* File: interval_timer_pkg.sv */
// constants and types of the interval and time-base timer
package interval_timer_pkg;

  localparam int ADDR_W = 18;

  // ----------------------------------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [15:0] MODE_IDX = 16'hFFB0;
  localparam logic [15:0] COUNT_IDX = 16'hFFB1;
  localparam logic [15:0] STAT_IDX = 16'hFFB4;
  localparam logic [15:0] MASK_IDX = 16'hFFB5;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_RST = 8'h10;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] RSVD_MASK = 8'h10;
  localparam int CLKOUT_LSB = 5;
  localparam int BASE_BIT = 3;
  localparam int CLR_BIT = 2;
  localparam int OVF_BIT = 0;

  // ----------------------------------------------------------------
  // prescalers: system one spans /8192, subclock one spans /128
  // ----------------------------------------------------------------
  localparam int SYS_PRE_W = 13;
  localparam int SUB_PRE_W = 7;
  localparam int SUBCLK_HZ = 32768;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    PM_ACTIVE = 3'b000,
    PM_SLEEP = 3'b001,
    PM_WATCH = 3'b010,
    PM_SUBACTIVE = 3'b011,
    PM_SUBSLEEP = 3'b100,
    PM_STANDBY = 3'b101
  } power_mode_t;

endpackage

/* File: tb.sv */
// self-checking testbench of the interval and time-base timer
`timescale 1ns/100ps
module tb;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [interval_timer_pkg::ADDR_W-1:0] awaddr = '0;
  logic [interval_timer_pkg::ADDR_W-1:0] araddr = '0;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic subclk = 1'b0, oe = 1'b0;
  logic [2:0] pmode = interval_timer_pkg::PM_ACTIVE;
  logic awready, wready, bvalid, arready, rvalid, dclk, irq;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;

  interval_timer interval_timer_i (.clk_in(clk_in), .rstn_in(rstn_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .subclk_in(subclk),
    .power_mode_in(pmode), .clkout_enable_in(oe), .divided_clock_out(dclk), .irq_out(irq));

  initial forever #5 clk_in = ~clk_in;
  // subclock sped up to 16 system cycles a period so time-base counts stay short
  initial begin
    #37;
    forever #80 subclk = ~subclk;
  end
  always @(posedge clk_in) cyc <= cyc + 1;

  // ----------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic rng(input string what, input int lo, input int hi,
                     input logic signed [31:0] got);
    num_checks++;
    if ($isunknown(got) || got < lo || got > hi) begin
      err_total++;
      $display("unexpected %s: expected %0d..%0d, seen %0d", what, lo, hi, got);
    end
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    @(posedge clk_in);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // no wait limit here: only the watchdog ends a stuck transfer
    forever begin
      @(posedge clk_in);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
    chk("write taken", 32'h0, {30'h0, awvalid, wvalid});
  endtask

  task automatic rdr(input logic [15:0] idx);
    @(posedge clk_in);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk_in);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
        break;
      end
    end
    chk("read taken", 32'h0, {31'h0, arvalid});
  endtask

  task automatic rchk(input string what, input logic [15:0] idx, input logic [7:0] exp);
    rdr(idx);
    chk(what, {24'h000000, exp}, rd);
    chk("read resp", {30'h0, interval_timer_pkg::RESP_OKAY}, {30'h0, resp});
  endtask

  // count advance over a wait; the read itself adds a few cycles, hence the range
  task automatic dlt(input string what, input int cycles, input int lo, input int hi);
    logic [7:0] a;
    logic [7:0] d;
    rdr(interval_timer_pkg::COUNT_IDX);
    a = rd[7:0];
    repeat (cycles) @(posedge clk_in);
    rdr(interval_timer_pkg::COUNT_IDX);
    d = rd[7:0] - a;
    rng(what, lo, hi, {24'h000000, d});
  endtask

  // cycles between two rising edges of the clock output, -1 if none within lim
  task automatic meas(input int lim, output int p);
    int c;
    int r1;
    logic prev;
    r1 = -1;
    p = -1;
    // skip the edge where a new select lands, it can fake a short period
    @(posedge clk_in);
    prev = dclk;
    for (c = 0; c < lim && p < 0; c++) begin
      @(posedge clk_in);
      if (dclk === 1'b1 && prev === 1'b0) begin
        if (r1 < 0) r1 = c;
        else p = c - r1;
      end
      prev = dclk;
    end
  endtask

  task automatic wirq(output int t);
    int n;
    for (n = 0; n < 3000; n++) begin
      @(posedge clk_in);
      if (irq === 1'b1) break;
    end
    t = cyc;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rchk("mode at reset", interval_timer_pkg::MODE_IDX, 8'h10);
    rchk("status at reset", interval_timer_pkg::STAT_IDX, 8'h00);
    chk("irq at reset", 32'h0, {31'h0, irq});
    dlt("reset tap count", 2 * 8192, 2, 3);
    $display("test reset done");
  endtask

  task automatic t_regs();
    wr(interval_timer_pkg::MODE_IDX, 8'h00);
    rchk("mode bit 4", interval_timer_pkg::MODE_IDX, 8'h10);
    wr(interval_timer_pkg::MODE_IDX, 8'hEF);
    rchk("mode all ones", interval_timer_pkg::MODE_IDX, 8'hFF);
    wstrb <= 4'hE;
    wr(interval_timer_pkg::MODE_IDX, 8'h00);
    wstrb <= 4'hF;
    rchk("mode lane 0 off", interval_timer_pkg::MODE_IDX, 8'hFF);
    wr(interval_timer_pkg::COUNT_IDX, 8'h55);
    rchk("count held", interval_timer_pkg::COUNT_IDX, 8'h00);
    repeat (300) @(posedge clk_in);
    rchk("count still held", interval_timer_pkg::COUNT_IDX, 8'h00);
    rdr(16'h0100);
    chk("unmapped read resp", 32'h2, {30'h0, resp});
    chk("unmapped read data", 32'h0, rd);
    wr(16'h0100, 8'h01);
    chk("unmapped write resp", 32'h2, {30'h0, resp});
    $display("test registers done");
  endtask

  task automatic t_interval();
    int divs[8] = '{8192, 4096, 2048, 512, 256, 128, 32, 8};
    for (int c = 1; c < 8; c++) begin
      wr(interval_timer_pkg::MODE_IDX, 8'(c));
      dlt("interval tap count", 2 * divs[c], 2, 3);
    end
    $display("test interval done");
  endtask

  task automatic t_timebase();
    int ticks[4] = '{128, 64, 32, 4};
    for (int c = 0; c < 4; c++) begin
      wr(interval_timer_pkg::MODE_IDX, 8'(8 + c));
      dlt("time base count", 2 * ticks[c] * 16, 2, 3);
    end
    $display("test time base done");
  endtask

  task automatic t_modes();
    wr(interval_timer_pkg::MODE_IDX, 8'h0B);
    pmode <= interval_timer_pkg::PM_WATCH;
    dlt("time base in watch", 128, 2, 3);
    pmode <= interval_timer_pkg::PM_STANDBY;
    dlt("time base in standby", 128, 0, 0);
    pmode <= interval_timer_pkg::PM_SUBACTIVE;
    rchk("count in subactive", interval_timer_pkg::COUNT_IDX, 8'h00);
    wr(interval_timer_pkg::MODE_IDX, 8'h07);
    pmode <= interval_timer_pkg::PM_WATCH;
    dlt("interval in watch", 64, 0, 0);
    pmode <= interval_timer_pkg::PM_SLEEP;
    dlt("interval in sleep", 32, 4, 5);
    pmode <= interval_timer_pkg::PM_ACTIVE;
    $display("test power modes done");
  endtask

  task automatic t_overflow();
    int t0;
    int t1;
    wr(interval_timer_pkg::MASK_IDX, 8'h00);
    wr(interval_timer_pkg::MODE_IDX, 8'h0C);
    wr(interval_timer_pkg::STAT_IDX, 8'h01);
    wr(interval_timer_pkg::MODE_IDX, 8'h07);
    repeat (2048 + 30) @(posedge clk_in);
    rchk("overflow flag", interval_timer_pkg::STAT_IDX, 8'h01);
    chk("masked irq", 32'h0, {31'h0, irq});
    wr(interval_timer_pkg::MASK_IDX, 8'h01);
    repeat (3) @(posedge clk_in);
    chk("unmasked irq", 32'h1, {31'h0, irq});
    wr(interval_timer_pkg::STAT_IDX, 8'h01);
    repeat (3) @(posedge clk_in);
    chk("cleared irq", 32'h0, {31'h0, irq});
    wirq(t0);
    wr(interval_timer_pkg::STAT_IDX, 8'h01);
    repeat (3) @(posedge clk_in);
    wirq(t1);
    rng("overflow period", 2048, 2048, t1 - t0);
    wr(interval_timer_pkg::MASK_IDX, 8'h00);
    $display("test overflow done");
  endtask

  task automatic t_clkout();
    int p;
    int e;
    oe <= 1'b1;
    for (int s = 0; s < 8; s++) begin
      wr(interval_timer_pkg::MODE_IDX, {3'(s), 5'h00});
      e = (s < 4) ? (32 >> s) : (32 >> (s - 4)) * 16;
      meas(2000, p);
      rng("clock out period", (s < 4) ? e : e - 2, (s < 4) ? e : e + 2, p);
    end
    oe <= 1'b0;
    meas(600, p);
    rng("clock out disabled", -1, -1, p);
    oe <= 1'b1;
    pmode <= interval_timer_pkg::PM_SUBACTIVE;
    wr(interval_timer_pkg::MODE_IDX, 8'h00);
    meas(300, p);
    rng("system clock out in subactive", -1, -1, p);
    wr(interval_timer_pkg::MODE_IDX, 8'hE0);
    meas(600, p);
    rng("subclock out in subactive", 62, 66, p);
    pmode <= interval_timer_pkg::PM_WATCH;
    meas(300, p);
    rng("subclock out in watch", -1, -1, p);
    pmode <= interval_timer_pkg::PM_ACTIVE;
    $display("test clock out done");
  endtask

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // tests need about 50k cycles; the limit leaves margin yet stays short
  initial begin
    #800000;
    err_total++;
    end_of_test();
  end

  initial begin
    repeat (5) @(posedge clk_in);
    rstn_in <= 1'b1;
    t_reset();
    t_regs();
    t_interval();
    t_timebase();
    t_modes();
    t_overflow();
    t_clkout();
    end_of_test();
  end
endmodule
